// File: verilog/srd_defs.svh
// register map, field positions, reset values and timing of the serial port
`ifndef SRD_DEFS_SVH
`define SRD_DEFS_SVH
`define SRD_BAUD_OFS 8'h00
`define SRD_CFG_OFS 8'h04
`define SRD_RTSON_OFS 8'h08
`define SRD_RTSOFF_OFS 8'h0c
`define SRD_TXDATA_OFS 8'h10
`define SRD_RXDATA_OFS 8'h14
`define SRD_STAT_OFS 8'h18
`define SRD_CFG_PAR_LSB 0
`define SRD_CFG_DATA8_BIT 3
`define SRD_CFG_STOP2_BIT 4
`define SRD_CFG_FLOW_LSB 5
`define SRD_CFG_FIFO_BIT 7
`define SRD_CFG_IFACE_LSB 8
`define SRD_CFG_WIDTH 10
`define SRD_BAUD_WIDTH 22
`define SRD_BAUD_RST 22'h00043d
`define SRD_CFG_RST 10'h088
`define SRD_DLY_RST 7'h00
`define SRD_RX_VALID_BIT 31
`define SRD_ST_TXFULL 0
`define SRD_ST_TXEMPTY 1
`define SRD_ST_RXVALID 2
`define SRD_ST_TXBUSY 3
`define SRD_ST_RTS 4
`define SRD_ST_CTS 5
`define SRD_ST_OVR 6
`define SRD_ST_PERR 7
`define SRD_ST_FERR 8
`define SRD_CLK_HZ 125000000
`define SRD_CLK_NS 8
`define SRD_MS_NS 1000000
`define SRD_BAUD_MIN_BPS 50
`define SRD_BAUD_MAX_BPS 921600
`define SRD_DLY_MAX_MS 100
`define SRD_FIFO_DEPTH 32
`endif

// File: verilog/srd_pkg.sv
// types and parity helper shared by the serial port modules
`default_nettype none
package srd_pkg;
    typedef enum logic [2:0] {
        PAR_NONE = 3'h0, PAR_ODD = 3'h1, PAR_EVEN = 3'h2,
        PAR_MARK = 3'h3, PAR_SPACE = 3'h4
    } srd_parity_e;
    typedef enum logic [1:0] {
        FLOW_NONE = 2'h0, FLOW_RTSCTS = 2'h1, FLOW_TOGGLE = 2'h2
    } srd_flow_e;
    typedef enum logic [1:0] {
        IF_RS232 = 2'h0, IF_RS422 = 2'h1, IF_RS485_2W = 2'h2,
        IF_RS485_4W = 2'h3
    } srd_iface_e;
    typedef enum logic [3:0] {
        TG_IDLE = 4'h1, TG_ON = 4'h2, TG_SEND = 4'h4, TG_OFF = 4'h8
    } srd_rts_e;

    function automatic logic srd_par_bit(input logic [7:0] d,
        input logic data8, input srd_parity_e p);
        logic x;
        x = ^(data8 ? d : {1'b0, d[6:0]});
        case (p)
            PAR_ODD: return ~x;
            PAR_EVEN: return x;
            PAR_MARK: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
endpackage
`default_nettype wire

// File: verilog/srd_fifo.sv
// character fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
`include "srd_defs.svh"
module srd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `SRD_FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    // depth must be a power of two: pointers wrap with one extra bit
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_q;
    logic [AW:0] rdPtr_q;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;

    assign outValid = wrPtr_q != rdPtr_q;
    assign inReady = !(wrPtr_q[AW] != rdPtr_q[AW]
        && wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
    assign outData = mem[rdPtr_q[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (push) mem[wrPtr_q[AW-1:0]] <= inData;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (push) wrPtr_q <= wrPtr_q + 1'b1;
            if (pop) rdPtr_q <= rdPtr_q + 1'b1;
        end
    end
endmodule // srd_fifo
`default_nettype wire

// File: verilog/srd_rx.sv
// serial receiver: start detect, mid-bit sampling, parity and stop check
`timescale 1ns/1ns
`default_nettype none
`include "srd_defs.svh"
module srd_rx
    import srd_pkg::*;
#(
    parameter int BW = `SRD_BAUD_WIDTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // line and setup
    input wire logic rxd,
    input wire logic rxEn,
    input wire logic [BW-1:0] baudDiv,
    input wire logic data8,
    input wire srd_parity_e parity,
    // received character
    output logic chValid,
    output logic [7:0] chData,
    output logic chPerr,
    output logic chFerr
);
    logic busy_q;
    logic [3:0] idx_q;
    logic [BW-1:0] cnt_q;
    logic [10:0] bits_q;
    wire hasPar = parity != PAR_NONE;
    wire [3:0] parIdx = data8 ? 4'd9 : 4'd8;
    wire [3:0] stopIdx = parIdx + {3'b0, hasPar};
    wire tick = busy_q && cnt_q == '0;
    wire [7:0] dataNow = data8 ? bits_q[8:1] : {1'b0, bits_q[7:1]};

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
            idx_q <= '0;
            cnt_q <= '0;
            bits_q <= '0;
        end else if (!rxEn) begin
            busy_q <= 1'b0;
        end else if (!busy_q) begin
            // first sample lands in the middle of the start bit
            if (!rxd) begin
                busy_q <= 1'b1;
                cnt_q <= baudDiv >> 1;
                idx_q <= '0;
            end
        end else if (!tick) begin
            cnt_q <= cnt_q - 1'b1;
        end else begin
            bits_q[idx_q] <= rxd;
            cnt_q <= baudDiv - 1'b1;
            if ((idx_q == 4'd0 && rxd) || idx_q == stopIdx) busy_q <= 1'b0;
            else idx_q <= idx_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            chValid <= 1'b0;
            chData <= '0;
            chPerr <= 1'b0;
            chFerr <= 1'b0;
        end else begin
            chValid <= rxEn && tick && idx_q == stopIdx;
            if (tick && idx_q == stopIdx) begin
                chData <= dataNow;
                chFerr <= !rxd;
                chPerr <= hasPar && bits_q[parIdx]
                    != srd_par_bit(dataNow, data8, parity);
            end
        end
    end
endmodule // srd_rx
`default_nettype wire

// File: verilog/srd_serial_port.sv
// serial port top: apb registers, transmitter, rts and line driver control
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "srd_defs.svh"

module srd_serial_port
    import srd_pkg::*;
#(
    parameter int unsigned DIV_MAX = `SRD_CLK_HZ / `SRD_BAUD_MIN_BPS,
    parameter int unsigned MS_CYCLES = `SRD_MS_NS / `SRD_CLK_NS,
    parameter int DEPTH = `SRD_FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial line
    output logic txd,
    input wire logic rxd,
    output logic rts,
    input wire logic cts,
    output logic drvEn,
    output logic rcvEn
);
    localparam int unsigned DIV_MIN = `SRD_CLK_HZ / `SRD_BAUD_MAX_BPS;
    localparam int BW = `SRD_BAUD_WIDTH;
    localparam logic [6:0] DLY_MAX = 7'(`SRD_DLY_MAX_MS);

    logic [BW-1:0] baudDiv_q;
    logic [`SRD_CFG_WIDTH-1:0] cfg_q;
    logic [6:0] onMs_q;
    logic [6:0] offMs_q;
    logic ovr_q;
    logic perrSt_q;
    logic ferrSt_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic txd_q;
    logic rts_q;
    logic drvEn_q;
    logic rcvEn_q;
    logic txBusy_q;
    logic [10:0] txShift_q;
    logic [3:0] txLeft_q;
    logic [BW-1:0] txCnt_q;
    srd_rts_e tgl_q;
    srd_rts_e tglNext;
    logic [31:0] presc_q;
    logic [6:0] msCnt_q;
    logic [31:0] rdMux;
    logic mapped;
    logic [11:0] txFrame;
    logic [3:0] txLen;
    logic txPermit;

    srd_parity_e parity;
    srd_flow_e flow;
    srd_iface_e iface;
    assign parity = srd_parity_e'(cfg_q[`SRD_CFG_PAR_LSB +: 3]);
    assign flow = srd_flow_e'(cfg_q[`SRD_CFG_FLOW_LSB +: 2]);
    assign iface = srd_iface_e'(cfg_q[`SRD_CFG_IFACE_LSB +: 2]);
    wire data8 = cfg_q[`SRD_CFG_DATA8_BIT];
    wire stop2 = cfg_q[`SRD_CFG_STOP2_BIT];
    wire fifoEn = cfg_q[`SRD_CFG_FIFO_BIT];
    wire tglOn = flow == FLOW_TOGGLE && iface == IF_RS232;

    // apb handshake
    wire apbAcc = psel && penable;
    wire apbDone = apbAcc && pready_q;
    wire apbWr = apbDone && pwrite;
    wire isTx = paddr == `SRD_TXDATA_OFS;
    wire isRx = paddr == `SRD_RXDATA_OFS;
    wire isSt = paddr == `SRD_STAT_OFS;

    // fifos
    wire txInRaw;
    wire txOutValid;
    wire [7:0] txOutData;
    wire txGo;
    wire rxInRaw;
    wire rxOutValid;
    wire [9:0] rxOutData;
    wire chValid;
    wire [7:0] chData;
    wire chPerr;
    wire chFerr;
    // with the fifo off only one character is held at a time
    wire txInRdy = txInRaw && (fifoEn || !txOutValid);
    wire rxPushOk = rxInRaw && (fifoEn || !rxOutValid);
    wire rxPop = apbDone && !pwrite && isRx && prdata_q[`SRD_RX_VALID_BIT];

    srd_fifo #(.WIDTH(8), .DEPTH(DEPTH)) txFifo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .inValid(apbWr && isTx),
        .inReady(txInRaw),
        .inData(pwdata[7:0]),
        .outValid(txOutValid),
        .outReady(txGo),
        .outData(txOutData)
    );

    srd_fifo #(.WIDTH(10), .DEPTH(DEPTH)) rxFifo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .inValid(chValid && rxPushOk),
        .inReady(rxInRaw),
        .inData({chFerr, chPerr, chData}),
        .outValid(rxOutValid),
        .outReady(rxPop),
        .outData(rxOutData)
    );

    srd_rx #(.BW(BW)) rxUnit (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .rxd(rxd),
        .rxEn(rcvEn_q),
        .baudDiv(baudDiv_q),
        .data8(data8),
        .parity(parity),
        .chValid(chValid),
        .chData(chData),
        .chPerr(chPerr),
        .chFerr(chFerr)
    );

    // register read view
    always_comb begin
        rdMux = '0;
        mapped = 1'b1;
        case (paddr)
            `SRD_BAUD_OFS: rdMux[BW-1:0] = baudDiv_q;
            `SRD_CFG_OFS: rdMux[`SRD_CFG_WIDTH-1:0] = cfg_q;
            `SRD_RTSON_OFS: rdMux[6:0] = onMs_q;
            `SRD_RTSOFF_OFS: rdMux[6:0] = offMs_q;
            `SRD_TXDATA_OFS: rdMux = '0;
            `SRD_RXDATA_OFS: begin
                rdMux[`SRD_RX_VALID_BIT] = rxOutValid;
                rdMux[9:0] = rxOutData;
            end
            `SRD_STAT_OFS: begin
                rdMux[`SRD_ST_TXFULL] = !txInRdy;
                rdMux[`SRD_ST_TXEMPTY] = !txOutValid;
                rdMux[`SRD_ST_RXVALID] = rxOutValid;
                rdMux[`SRD_ST_TXBUSY] = txBusy_q;
                rdMux[`SRD_ST_RTS] = rts_q;
                rdMux[`SRD_ST_CTS] = cts;
                rdMux[`SRD_ST_OVR] = ovr_q;
                rdMux[`SRD_ST_PERR] = perrSt_q;
                rdMux[`SRD_ST_FERR] = ferrSt_q;
            end
            default: mapped = 1'b0;
        endcase
    end

    // answer one cycle into the access phase; a full tx fifo stalls it
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else if (apbAcc && !pready_q) begin
            if (!(pwrite && isTx && !txInRdy)) begin
                pready_q <= 1'b1;
                pslverr_q <= !mapped;
                prdata_q <= pwrite ? 32'h0000_0000 : rdMux;
            end
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // configuration; out-of-range values are clamped
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            baudDiv_q <= `SRD_BAUD_RST;
            cfg_q <= `SRD_CFG_RST;
            onMs_q <= `SRD_DLY_RST;
            offMs_q <= `SRD_DLY_RST;
        end else if (apbWr) begin
            case (paddr)
                `SRD_BAUD_OFS: begin
                    if (pwdata > DIV_MAX) baudDiv_q <= BW'(DIV_MAX);
                    else if (pwdata < DIV_MIN) baudDiv_q <= BW'(DIV_MIN);
                    else baudDiv_q <= pwdata[BW-1:0];
                end
                `SRD_CFG_OFS: cfg_q <= pwdata[`SRD_CFG_WIDTH-1:0];
                `SRD_RTSON_OFS:
                    onMs_q <= pwdata > 32'(DLY_MAX) ? DLY_MAX : pwdata[6:0];
                `SRD_RTSOFF_OFS:
                    offMs_q <= pwdata > 32'(DLY_MAX) ? DLY_MAX : pwdata[6:0];
                default: ;
            endcase
        end
    end

    // sticky receive errors, write one to clear; a new event wins
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ovr_q <= 1'b0;
            perrSt_q <= 1'b0;
            ferrSt_q <= 1'b0;
        end else begin
            ovr_q <= (chValid && !rxPushOk)
                || (ovr_q && !(apbWr && isSt && pwdata[`SRD_ST_OVR]));
            perrSt_q <= (chValid && chPerr)
                || (perrSt_q && !(apbWr && isSt && pwdata[`SRD_ST_PERR]));
            ferrSt_q <= (chValid && chFerr)
                || (ferrSt_q && !(apbWr && isSt && pwdata[`SRD_ST_FERR]));
        end
    end

    // frame image, lsb first: start, data, parity, stop bits
    always_comb begin
        txFrame = '1;
        txFrame[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i < 7 || data8) txFrame[i+1] = txOutData[i];
        end
        if (parity != PAR_NONE) begin
            txFrame[data8 ? 9 : 8] = srd_par_bit(txOutData, data8, parity);
        end
        txLen = (data8 ? 4'd10 : 4'd9) + {3'b0, parity != PAR_NONE}
            + {3'b0, stop2};
    end

    always_comb begin
        if (flow == FLOW_RTSCTS) txPermit = cts;
        else if (tglOn) txPermit = tgl_q == TG_SEND;
        else txPermit = 1'b1;
    end
    assign txGo = txOutValid && !txBusy_q && txPermit;

    // transmitter shift engine
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            txBusy_q <= 1'b0;
            txShift_q <= '1;
            txLeft_q <= '0;
            txCnt_q <= '0;
            txd_q <= 1'b1;
        end else if (txGo) begin
            txBusy_q <= 1'b1;
            txd_q <= txFrame[0];
            txShift_q <= txFrame[11:1];
            txLeft_q <= txLen - 4'd1;
            txCnt_q <= baudDiv_q - 1'b1;
        end else if (txBusy_q) begin
            if (txCnt_q != '0) begin
                txCnt_q <= txCnt_q - 1'b1;
            end else if (txLeft_q == 4'd0) begin
                txBusy_q <= 1'b0;
            end else begin
                txd_q <= txShift_q[0];
                txShift_q <= {1'b1, txShift_q[10:1]};
                txLeft_q <= txLeft_q - 4'd1;
                txCnt_q <= baudDiv_q - 1'b1;
            end
        end
    end

    // rts toggle sequencing
    wire tmrDone = msCnt_q == (tgl_q == TG_ON ? onMs_q : offMs_q);
    always_comb begin
        tglNext = tgl_q;
        if (!tglOn) begin
            tglNext = TG_IDLE;
        end else begin
            case (tgl_q)
                TG_IDLE: if (txOutValid) tglNext = TG_ON;
                TG_ON: if (tmrDone) tglNext = TG_SEND;
                TG_SEND: if (!txOutValid && !txBusy_q) tglNext = TG_OFF;
                TG_OFF: begin
                    if (txOutValid) tglNext = TG_SEND;
                    else if (tmrDone) tglNext = TG_IDLE;
                end
                default: tglNext = TG_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) tgl_q <= TG_IDLE;
        else tgl_q <= tglNext;
    end

    // millisecond timer restarts on every state change
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            presc_q <= '0;
            msCnt_q <= '0;
        end else if (tglNext != tgl_q) begin
            presc_q <= '0;
            msCnt_q <= '0;
        end else if (presc_q >= MS_CYCLES - 1) begin
            presc_q <= '0;
            if (msCnt_q != 7'h7f) msCnt_q <= msCnt_q + 7'h01;
        end else begin
            presc_q <= presc_q + 32'h0000_0001;
        end
    end

    // line control outputs
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rts_q <= 1'b0;
            drvEn_q <= 1'b0;
            rcvEn_q <= 1'b0;
        end else begin
            if (tglOn) rts_q <= tglNext != TG_IDLE;
            else if (flow == FLOW_RTSCTS) rts_q <= rxPushOk;
            else rts_q <= 1'b1;
            case (iface)
                IF_RS485_2W: begin
                    // half duplex: receiver off so our own echo is ignored
                    drvEn_q <= txGo || txBusy_q;
                    rcvEn_q <= !(txGo || txBusy_q);
                end
                IF_RS485_4W: begin
                    drvEn_q <= txGo || txBusy_q;
                    rcvEn_q <= 1'b1;
                end
                default: begin
                    drvEn_q <= 1'b1;
                    rcvEn_q <= 1'b1;
                end
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign txd = txd_q;
    assign rts = rts_q;
    assign drvEn = drvEn_q;
    assign rcvEn = rcvEn_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_tgl_quiet;
        (tglOn && tgl_q == TG_IDLE)[*2];
    endsequence
    sequence s_tgl_start;
        tglOn && tgl_q == TG_IDLE && txOutValid;
    endsequence

    a_baud_range: assert property (
        baudDiv_q >= BW'(DIV_MIN) && baudDiv_q <= BW'(DIV_MAX))
        else $error("baud divisor out of range");
    a_parity_bit: assert property (
        txGo && parity != PAR_NONE |-> txFrame[data8 ? 9 : 8]
            == srd_par_bit(txOutData, data8, parity))
        else $error("parity bit wrong");
    a_frame_start: assert property (
        txGo |=> txd_q == 1'b0 && txBusy_q && txLeft_q == $past(txLen) - 4'd1)
        else $error("frame start or length wrong");
    a_half_duplex: assert property (
        iface == IF_RS485_2W && $past(iface) == IF_RS485_2W
            && $past(txBusy_q) |-> drvEn_q && !rcvEn_q)
        else $error("two-wire driver or receiver enable wrong");
    a_tgl_quiet_rts: assert property (
        s_tgl_quiet |-> !rts_q)
        else $error("rts on while toggle idle");
    a_tgl_on_first: assert property (
        s_tgl_start |=> tgl_q == TG_ON && rts_q && !txBusy_q)
        else $error("toggle did not raise rts before sending");
    a_tgl_off_wait: assert property (
        tgl_q == TG_OFF |-> !txBusy_q && rts_q)
        else $error("rts off wait while transmitting");
    a_delay_range: assert property (
        onMs_q <= DLY_MAX && offMs_q <= DLY_MAX)
        else $error("rts delay above limit");
    a_tgl_rs232: assert property (
        tgl_q != TG_IDLE |-> $past(iface) == IF_RS232)
        else $error("toggle active off rs-232");
    a_fifo_single: assert property (
        !fifoEn && txOutValid |-> !txInRdy)
        else $error("fifo off holds more than one character");
    a_cts_gate: assert property (
        txGo && flow == FLOW_RTSCTS |-> cts)
        else $error("sent without cts");
endmodule // srd_serial_port
`default_nettype wire

// File: tb/srd_far_station.sv
// far serial station: captures txd frames, sends rxd frames, drives cts
`timescale 1ns/1ns
`default_nettype none
module srd_far_station (
    // clock
    input wire logic core_clk,
    // serial line
    input wire logic txd,
    output logic rxd,
    output logic cts,
    // frame setup from the bench
    input wire logic [21:0] div,
    input wire logic [3:0] nBits,
    input wire logic ctsOn
);
    logic [11:0] got[$];
    assign cts = ctsOn;
    initial rxd = 1'b1;
    // mid-bit sampling; bits after the start bit, lsb first
    always begin : cap
        logic [11:0] f;
        wait (txd === 1'b0);
        f = 12'h000;
        repeat (div / 2) @(posedge core_clk);
        for (int i = 0; i < nBits; i++) begin
            repeat (div) @(posedge core_clk);
            f[i] = txd;
        end
        got.push_back(f);
    end
    task automatic send(input logic [11:0] f);
        rxd <= 1'b0;
        repeat (div) @(posedge core_clk);
        for (int i = 0; i < nBits; i++) begin
            rxd <= f[i];
            repeat (div) @(posedge core_clk);
        end
        // one idle bit so back-to-back sends never collide
        rxd <= 1'b1;
        repeat (div) @(posedge core_clk);
    endtask
endmodule // srd_far_station
`default_nettype wire

// File: tb/test_serial_port_with_rts_direction.sv
// self-checking bench: registers, frames, flow control, fifo
`timescale 1ns/1ns
`default_nettype none
`include "srd_defs.svh"
module test_serial_port_with_rts_direction;
    logic core_clk, arst_n, psel, penable, pwrite, ctsOn, d8, s2, e;
    logic pready, pslverr, txd, rxd, rts, cts, drvEn, rcvEn;
    logic [7:0] paddr, d;
    logic [31:0] pwdata, prdata, r;
    logic [21:0] div;
    logic [3:0] nb;
    logic [7:0] sent[$];
    int bad_count, check_count, n, s;

    srd_serial_port #(.DIV_MAX(5000), .MS_CYCLES(10)) i_dut (.core_clk,
        .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .txd, .rxd, .rts, .cts, .drvEn, .rcvEn);
    srd_far_station i_far (.core_clk, .txd, .rxd, .cts, .div,
        .nBits(nb), .ctsOn);

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic stop_test;
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            bad_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic bit1(input logic seen, input logic want);
        check({31'h0, seen}, {31'h0, want});
    endtask
    task automatic guard(inout int c);
        c++;
        if (c > 9000) begin
            bad_count++;
            stop_test();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        int c;
        c = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            guard(c);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        apb(1'b0, a, 32'h0);
        check(r, want);
    endtask
    task automatic cfg(input logic [2:0] p, input logic [1:0] fl,
        input logic fo, input logic [1:0] ifc);
        nb = 4'(8 + d8 + (p != 3'h0) + s2);
        apb(1'b1, `SRD_CFG_OFS, {22'h0, ifc, fo, fl, s2, d8, p});
    endtask
    // bits after the start bit: data, parity if any, stop bits
    function automatic logic [11:0] frame(input logic [7:0] v,
        input logic [2:0] p);
        logic [11:0] f;
        int k;
        k = d8 ? 8 : 7;
        f = d8 ? {4'h0, v} : {5'h0, v[6:0]};
        if (p != 3'h0) begin
            f[k] = (p == 3'h1) ? ~^f : (p == 3'h2) ? ^f : (p == 3'h3);
            k++;
        end
        f[k] = 1'b1;
        if (s2) f[k+1] = 1'b1;
        return f;
    endfunction
    task automatic txchk(input logic [11:0] want);
        n = 0;
        while (i_far.got.size() == 0) begin
            @(posedge core_clk);
            guard(n);
        end
        check({20'h0, i_far.got.pop_front()}, {20'h0, want});
    endtask
    task automatic rxchk(input logic [31:0] want);
        n = 0;
        do begin
            apb(1'b0, `SRD_STAT_OFS, 32'h0);
            guard(n);
        end while (r[`SRD_ST_RXVALID] !== 1'b1);
        rd(`SRD_RXDATA_OFS, want);
    endtask

    initial begin
        void'($urandom(32'h1526));
        {arst_n, psel, penable, pwrite, ctsOn, d8, s2} = 7'b0000110;
        paddr = 8'h00;
        pwdata = 32'h0;
        div = 22'd135;
        nb = 4'd9;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        rd(`SRD_BAUD_OFS, 32'h43d);
        rd(`SRD_CFG_OFS, 32'h88);
        rd(`SRD_RTSON_OFS, 32'h0);
        rd(`SRD_RTSOFF_OFS, 32'h0);
        bit1(rts, 1'b1);
        apb(1'b0, 8'h1c, 32'h0);
        check({e, r[30:0]}, 32'h8000_0000);
        apb(1'b1, `SRD_BAUD_OFS, 32'h5);
        rd(`SRD_BAUD_OFS, 32'h87);
        apb(1'b1, `SRD_RTSON_OFS, 32'hc8);
        rd(`SRD_RTSON_OFS, 32'h64);
        apb(1'b1, `SRD_RTSON_OFS, 32'h1);
        apb(1'b1, `SRD_RTSOFF_OFS, 32'h2);
        for (int p = 0; p < 5; p++) begin
            d8 = 1'($urandom);
            s2 = 1'($urandom);
            cfg(3'(p), 2'h0, 1'b1, 2'h0);
            d = 8'($urandom);
            apb(1'b1, `SRD_TXDATA_OFS, {24'h0, d});
            txchk(frame(d, 3'(p)));
            d = 8'($urandom);
            i_far.send(frame(d, 3'(p)));
            rxchk({24'h800000, d & {d8, 7'h7f}});
        end
        // cts low stalls the sender while the fifo fills up
        {d8, s2} = 2'b10;
        cfg(3'h0, 2'h1, 1'b1, 2'h0);
        ctsOn <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            sent.push_back(8'($urandom));
            apb(1'b1, `SRD_TXDATA_OFS, {24'h0, sent[i]});
        end
        apb(1'b0, `SRD_STAT_OFS, 32'h0);
        bit1(r[`SRD_ST_TXFULL], 1'b1);
        check(32'(i_far.got.size()), 32'h0);
        bit1(rts, 1'b1);
        ctsOn <= 1'b1;
        foreach (sent[i]) txchk(frame(sent[i], 3'h0));
        // fifo off holds one character; the next is lost
        cfg(3'h0, 2'h0, 1'b0, 2'h0);
        i_far.send(frame(8'ha5, 3'h0));
        i_far.send(frame(8'h3c, 3'h0));
        rxchk(32'h8000_00a5);
        apb(1'b0, `SRD_STAT_OFS, 32'h0);
        bit1(r[`SRD_ST_OVR], 1'b1);
        i_far.send(frame(8'h5a, 3'h0) & 12'h0ff);
        rxchk(32'h8000_025a);
        cfg(3'h0, 2'h2, 1'b1, 2'h0);
        repeat (4) @(posedge core_clk);
        bit1(rts, 1'b0);
        apb(1'b1, `SRD_TXDATA_OFS, 32'h96);
        n = 0;
        s = 0;
        while (rts !== 1'b0 || s == 0) begin
            @(posedge core_clk);
            guard(n);
            if (txd === 1'b0 && s == 0) s = n;
        end
        bit1(s >= 8 && s <= 15, 1'b1);
        bit1(n - s >= 1368 && n - s <= 1376, 1'b1);
        txchk(frame(8'h96, 3'h0));
        cfg(3'h0, 2'h2, 1'b1, 2'h1);
        repeat (4) @(posedge core_clk);
        bit1(rts, 1'b1);
        cfg(3'h0, 2'h0, 1'b1, 2'h2);
        repeat (4) @(posedge core_clk);
        check({30'h0, drvEn, rcvEn}, 32'h1);
        apb(1'b1, `SRD_TXDATA_OFS, 32'h11);
        n = 0;
        while (txd !== 1'b0) begin
            @(posedge core_clk);
            guard(n);
        end
        @(posedge core_clk);
        check({30'h0, drvEn, rcvEn}, 32'h2);
        txchk(frame(8'h11, 3'h0));
        stop_test();
    end
endmodule // test_serial_port_with_rts_direction
`default_nettype wire
